// *** mgmt_master.sv ***
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------
// management controller model, single word transfers
// -------------------------------------------------------
module mgmt_master
  import phy_regmap_pkg::*;
(
  // clock
  input  wire logic        hclk,
  // request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // bus idle at time zero
  initial begin
    {hsel, hwrite, htrans, hsize} = '0;
    {haddr, hwdata} = '0;
  end

  // no wait count assumed, only the bench timeout ends a stall
  // callers write listed offsets only
  task automatic xfer(input logic wr, input logic [11:0] ofs, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {18'h0, ofs, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    // released address toggles so a stale value cannot pass
    haddr  <= ~haddr;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata[15:0];
    hwdata <= ~hwdata;
  endtask
endmodule

`default_nettype wire

// *** phy_regmap_pkg.sv ***
// Overview of operation
// R1 - A low sampled speed strap selects 10 Mb/s and a high one 100 Mb/s, with 100 Mb/s when unstrapped.
// R2 - A low sampled duplex strap selects half duplex and a high one full duplex.
// R3 - A high sampled isolate strap keeps the MAC-side interface isolated after reset, a low one leaves it active.
// R4 - The management registers answer at every listed offset from zero up to 0x4a7, extended ones included.
// R5 - Software treats every unlisted offset as reserved and does not write there.
// R6 - A write-zero-clears field is cleared by writing 0 and left alone by writing 1.
// R7 - Hardware-updated fields change on internal events regardless of writes, and reads show the live value.
// R8 - All strap levels are captured at power-up or hard reset and set the initial configuration.
// R9 - A software reset restores strap-derived settings from the captured values without resampling the pins.
// R10 - The speed-select control bit starts from the speed strap and stays writable by software.
// R11 - The duplex and isolate strap results are the reset values of their control fields.
package phy_regmap_pkg;

  // ---------------------------------------------------------------
  // register map, word index = byte address / 4
  // ---------------------------------------------------------------
  localparam int          NUM_REGS = 82;
  localparam int          OFS_W    = 12;
  localparam int          SLOT_W   = 7;
  localparam logic [11:0] REG_OFFSETS [0:NUM_REGS-1] = '{
    12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006, 12'h007, 12'h008, 12'h009,
    12'h00a, 12'h00b, 12'h00d, 12'h00e, 12'h00f, 12'h010, 12'h011, 12'h012, 12'h013, 12'h014,
    12'h015, 12'h016, 12'h017, 12'h018, 12'h019, 12'h01a, 12'h01b, 12'h01c, 12'h01e, 12'h01f,
    12'h025, 12'h027, 12'h02a, 12'h117, 12'h131, 12'h170, 12'h171, 12'h172, 12'h173, 12'h174,
    12'h175, 12'h176, 12'h177, 12'h178, 12'h180, 12'h181, 12'h182, 12'h183, 12'h184, 12'h185,
    12'h186, 12'h187, 12'h188, 12'h189, 12'h18a, 12'h302, 12'h303, 12'h304, 12'h305, 12'h306,
    12'h308, 12'h30b, 12'h30c, 12'h30e, 12'h404, 12'h40d, 12'h456, 12'h459, 12'h45a, 12'h460,
    12'h461, 12'h467, 12'h468, 12'h469, 12'h4a0, 12'h4a1, 12'h4a2, 12'h4a3, 12'h4a4, 12'h4a5,
    12'h4a6, 12'h4a7};

  // offsets with behaviour of their own
  localparam logic [11:0] OFS_BASIC_MODE_CONTROL    = 12'h000;
  localparam logic [11:0] OFS_BASIC_MODE_STATUS     = 12'h001;
  localparam logic [11:0] OFS_IDENTIFIER_UPPER      = 12'h002;
  localparam logic [11:0] OFS_IDENTIFIER_LOWER      = 12'h003;
  localparam logic [11:0] OFS_PHY_STATUS            = 12'h010;
  localparam logic [11:0] OFS_INTERRUPT_STATUS_ONE  = 12'h012;
  localparam logic [11:0] OFS_FALSE_CARRIER_COUNTER = 12'h014;
  localparam logic [11:0] OFS_RECEIVE_ERROR_COUNTER = 12'h015;

  // ---------------------------------------------------------------
  // basic_mode_control fields and reset value
  // ---------------------------------------------------------------
  localparam int          BMC_RESET      = 15;
  localparam int          BMC_LOOPBACK   = 14;
  localparam int          BMC_SPEED      = 13;
  localparam int          BMC_AUTONEG    = 12;
  localparam int          BMC_POWER_DOWN = 11;
  localparam int          BMC_ISOLATE    = 10;
  localparam int          BMC_DUPLEX     = 8;
  localparam logic [15:0] BMC_RESET_VALUE = 16'h3100;
  localparam logic [15:0] BMC_WRITE_MASK  = 16'h7d00;

  // unstrapped pin levels
  localparam logic SPEED_STRAP_DEFAULT   = 1'b1;
  localparam logic DUPLEX_STRAP_DEFAULT  = 1'b1;
  localparam logic ISOLATE_STRAP_DEFAULT = 1'b0;

  // ---------------------------------------------------------------
  // read-only and hardware-updated fields
  // ---------------------------------------------------------------
  localparam logic [15:0] BMS_ABILITIES   = 16'h7809;
  localparam int          BMS_LINK        = 2;
  localparam logic [15:0] ID_UPPER_VALUE  = 16'h1234; // arbitrary value
  localparam logic [15:0] ID_LOWER_VALUE  = 16'h5678; // arbitrary value
  localparam int          PST_LINK        = 0;
  localparam int          PST_SPEED_10    = 1;
  localparam int          PST_DUPLEX      = 2;
  localparam int          INT_LINK_CHANGE = 0;
  localparam int          INT_RX_ERROR    = 1;
  localparam int          INT_FALSE_CARR  = 2;
  localparam int          INT_FLAGS       = 3;
  localparam logic [15:0] COUNTER_MAX     = 16'hffff;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam logic [1:0]  STRAP_SETTLE_CYCLES = 2'h2;
  localparam int          SOFT_RESET_NS       = 64;
  localparam int          CLK_PERIOD_NS       = 8;
  localparam int          SOFT_RESET_CYCLES   = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // bus encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic speed_select_pin_option;
    logic duplex_select_pin_option;
    logic interface_isolate_pin_option;
  } strap_pins_s;

  typedef struct packed {
    logic link_up;
    logic resolved_speed_100;
    logic resolved_full_duplex;
    logic rx_error_event;
    logic false_carrier_event;
  } phy_state_s;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic mac_isolate;
    logic autoneg_enable;
    logic power_down;
    logic loopback;
    logic soft_reset_active;
    logic straps_valid;
  } phy_config_s;

endpackage

// *** phy_strap_and_register_map.sv ***
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module phy_strap_and_register_map
  import phy_regmap_pkg::*;
#(
  parameter int SRST_CYCLES = SOFT_RESET_CYCLES
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // strap pins and internal phy state
  input  wire strap_pins_s strap_pins,
  input  wire phy_state_s  phy_state,
  // resulting configuration
  output phy_config_s      phy_config
);

  localparam int SRST_BOUND = SRST_CYCLES + 2;

  // every check runs on the bus clock and sleeps while reset is low
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // search the map; returns hit flag and storage slot
  function automatic logic [SLOT_W:0] find_slot(input logic [OFS_W-1:0] ofs);
    logic [SLOT_W:0] res;
    res = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_OFFSETS[i] == ofs) begin
        res = {1'b1, SLOT_W'(i)};
      end
    end
    return res;
  endfunction

  // offsets that never use the generic storage
  function automatic logic is_special(input logic [OFS_W-1:0] ofs);
    return (ofs == OFS_BASIC_MODE_CONTROL) || (ofs == OFS_BASIC_MODE_STATUS) ||
           (ofs == OFS_IDENTIFIER_UPPER) || (ofs == OFS_IDENTIFIER_LOWER) ||
           (ofs == OFS_PHY_STATUS) || (ofs == OFS_INTERRUPT_STATUS_ONE) ||
           (ofs == OFS_FALSE_CARRIER_COUNTER) || (ofs == OFS_RECEIVE_ERROR_COUNTER);
  endfunction

  // counters stop at full scale rather than wrap
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == COUNTER_MAX) ? v : v + 16'h0001;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0]          mem [0:NUM_REGS-1];
  logic [15:0]          bmc;
  logic [INT_FLAGS-1:0] int_flags;
  logic [15:0]          rx_err_cnt;
  logic [15:0]          false_carr_cnt;
  logic                 link_prev;
  strap_pins_s          strap_meta;
  strap_pins_s          strap_sync;
  strap_pins_s          strap_latched;
  logic [1:0]           settle_cnt;
  logic                 strap_done;
  logic [7:0]           srst_cnt;
  logic                 wr_pend;
  logic                 wr_hit;
  logic [SLOT_W-1:0]    wr_slot;
  logic [OFS_W-1:0]     wr_ofs;
  logic                 rd_pend;
  logic                 rd_hit;
  logic [SLOT_W-1:0]    rd_slot;
  logic [OFS_W-1:0]     rd_ofs;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // only single word transfers are expected; hsize is not checked
  wire              take     = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire [OFS_W-1:0]  a_ofs    = haddr[OFS_W+1:2];
  wire [SLOT_W:0]   a_find   = find_slot(a_ofs);
  wire [15:0]       wdata    = hwdata[15:0];
  wire              commit   = wr_pend & hready & wr_hit;
  wire              wr_bmc   = commit & (wr_ofs == OFS_BASIC_MODE_CONTROL);
  wire              wr_int1  = commit & (wr_ofs == OFS_INTERRUPT_STATUS_ONE);
  wire              wr_plain = commit & !is_special(wr_ofs);
  wire              clr_rx   = rd_pend & rd_hit & (rd_ofs == OFS_RECEIVE_ERROR_COUNTER);
  wire              clr_fc   = rd_pend & rd_hit & (rd_ofs == OFS_FALSE_CARRIER_COUNTER);
  wire              unused_ok = &{1'b0, hsize, hwdata[31:16], haddr[31:OFS_W+2], haddr[1:0]};

  // address phase is latched; writes commit in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_hit  <= 1'b0;
      wr_slot <= '0;
      wr_ofs  <= '0;
      rd_pend <= 1'b0;
      rd_hit  <= 1'b0;
      rd_slot <= '0;
      rd_ofs  <= '0;
    end else begin
      wr_pend <= take & hwrite;
      rd_pend <= take & !hwrite;
      if (take) begin
        wr_hit  <= a_find[SLOT_W];
        wr_slot <= a_find[SLOT_W-1:0];
        wr_ofs  <= a_ofs;
        rd_hit  <= a_find[SLOT_W];
        rd_slot <= a_find[SLOT_W-1:0];
        rd_ofs  <= a_ofs;
      end
    end
  end

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  // pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_meta <= '{SPEED_STRAP_DEFAULT, DUPLEX_STRAP_DEFAULT, ISOLATE_STRAP_DEFAULT};
      strap_sync <= '{SPEED_STRAP_DEFAULT, DUPLEX_STRAP_DEFAULT, ISOLATE_STRAP_DEFAULT};
    end else begin
      strap_meta <= strap_pins;
      strap_sync <= strap_meta;
    end
  end

  // the pins are caught once the synchroniser has filled after release
  wire load_hard = !strap_done & (settle_cnt == STRAP_SETTLE_CYCLES);
  wire load_soft = (srst_cnt == 8'h01);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt    <= '0;
      strap_done    <= 1'b0;
      strap_latched <= '{SPEED_STRAP_DEFAULT, DUPLEX_STRAP_DEFAULT, ISOLATE_STRAP_DEFAULT};
    end else if (!strap_done) begin
      settle_cnt <= settle_cnt + 2'h1;
      if (load_hard) begin
        strap_done    <= 1'b1;
        strap_latched <= strap_sync; // R8
      end
    end
  end

  // a soft reload reuses the latched copy, never the live pins
  wire strap_pins_s strap_src = strap_done ? strap_latched : strap_sync; // R9

  // ---------------------------------------------------------------
  // soft reset sequencing
  // ---------------------------------------------------------------
  // the reset bit reads 1 while the count runs, then clears itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srst_cnt <= '0;
    end else if (wr_bmc & wdata[BMC_RESET]) begin
      srst_cnt <= 8'(SRST_CYCLES);
    end else if (srst_cnt != 8'h00) begin
      srst_cnt <= srst_cnt - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // basic_mode_control
  // ---------------------------------------------------------------
  wire [15:0] bmc_strapped = (BMC_RESET_VALUE & ~(16'h0001 << BMC_SPEED) & ~(16'h0001 << BMC_DUPLEX)
                              & ~(16'h0001 << BMC_ISOLATE))
                             | ({15'h0, strap_src.speed_select_pin_option} << BMC_SPEED)
                             | ({15'h0, strap_src.duplex_select_pin_option} << BMC_DUPLEX)
                             | ({15'h0, strap_src.interface_isolate_pin_option} << BMC_ISOLATE);
  wire [15:0] bmc_view = bmc | ({15'h0, (srst_cnt != 8'h00)} << BMC_RESET);

  // strap results become the field values; software may override later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bmc <= BMC_RESET_VALUE;
    end else if (load_hard | load_soft) begin
      bmc <= bmc_strapped; // R1 R2 R3 R11
    end else if (wr_bmc) begin
      bmc <= wdata & BMC_WRITE_MASK; // R10
    end
  end

  // ---------------------------------------------------------------
  // hardware-updated status
  // ---------------------------------------------------------------
  wire                 link_change = phy_state.link_up ^ link_prev;
  wire [INT_FLAGS-1:0] int_set     = {phy_state.false_carrier_event, phy_state.rx_error_event, link_change};
  wire [INT_FLAGS-1:0] int_clr     = wr_int1 ? ~wdata[INT_FLAGS-1:0] : '0;
  wire [15:0]          rx_base     = clr_rx ? 16'h0000 : rx_err_cnt;
  wire [15:0]          fc_base     = clr_fc ? 16'h0000 : false_carr_cnt;

  // events win over a clear in the same cycle so none is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_prev      <= 1'b0;
      int_flags      <= '0;
      rx_err_cnt     <= '0;
      false_carr_cnt <= '0;
    end else begin
      link_prev      <= phy_state.link_up;
      int_flags      <= (int_flags & ~int_clr) | int_set; // R6 R7
      rx_err_cnt     <= phy_state.rx_error_event ? sat_inc(rx_base) : rx_base; // R7
      false_carr_cnt <= phy_state.false_carrier_event ? sat_inc(fc_base) : fc_base; // R7
    end
  end

  // ---------------------------------------------------------------
  // generic storage
  // ---------------------------------------------------------------
  // unlisted offsets never reach here, so stray writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        mem[i] <= '0;
      end
    end else if (wr_plain) begin
      mem[wr_slot] <= wdata; // R4
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [15:0] bms_view = BMS_ABILITIES | ({15'h0, phy_state.link_up} << BMS_LINK);
  wire [15:0] pst_view = ({15'h0, phy_state.link_up} << PST_LINK)
                         | ({15'h0, !phy_config.speed_100} << PST_SPEED_10)
                         | ({15'h0, phy_config.full_duplex} << PST_DUPLEX);
  wire [15:0] rd_word =
    !rd_hit                                ? 16'h0000 :
    (rd_ofs == OFS_BASIC_MODE_CONTROL)     ? bmc_view :
    (rd_ofs == OFS_BASIC_MODE_STATUS)      ? bms_view :
    (rd_ofs == OFS_IDENTIFIER_UPPER)       ? ID_UPPER_VALUE :
    (rd_ofs == OFS_IDENTIFIER_LOWER)       ? ID_LOWER_VALUE :
    (rd_ofs == OFS_PHY_STATUS)             ? pst_view :
    (rd_ofs == OFS_INTERRUPT_STATUS_ONE)   ? {{(16-INT_FLAGS){1'b0}}, int_flags} :
    (rd_ofs == OFS_FALSE_CARRIER_COUNTER)  ? false_carr_cnt :
    (rd_ofs == OFS_RECEIVE_ERROR_COUNTER)  ? rx_err_cnt :
                                             mem[rd_slot];

  // reads take one wait state, so a write just before is always seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= '0;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= !(take & !hwrite);
      hresp     <= HRESP_OKAY;
      if (rd_pend) begin
        hrdata <= {16'h0000, rd_word}; // R4 R7
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  // with auto-negotiation on, the resolved link mode wins over the forced bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_config <= '{SPEED_STRAP_DEFAULT, DUPLEX_STRAP_DEFAULT, ISOLATE_STRAP_DEFAULT,
                      1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      phy_config.speed_100         <= bmc[BMC_AUTONEG] ? phy_state.resolved_speed_100 : bmc[BMC_SPEED]; // R1
      phy_config.full_duplex       <= bmc[BMC_AUTONEG] ? phy_state.resolved_full_duplex : bmc[BMC_DUPLEX]; // R2
      phy_config.mac_isolate       <= bmc[BMC_ISOLATE]; // R3
      phy_config.autoneg_enable    <= bmc[BMC_AUTONEG];
      phy_config.power_down        <= bmc[BMC_POWER_DOWN];
      phy_config.loopback          <= bmc[BMC_LOOPBACK] & !unused_ok;
      phy_config.soft_reset_active <= (srst_cnt != 8'h00);
      phy_config.straps_valid      <= strap_done;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_read_wait_state: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    take & !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

  a_unmapped_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    rd_pend & !rd_hit |=> hrdata == 32'h0000_0000)
    else $error("reserved offset read back nonzero");

  a_hard_strap_load: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    load_hard |=> bmc[BMC_SPEED] == $past(strap_sync.speed_select_pin_option)
                  && bmc[BMC_DUPLEX] == $past(strap_sync.duplex_select_pin_option)
                  && bmc[BMC_ISOLATE] == $past(strap_sync.interface_isolate_pin_option))
    else $error("strap levels not loaded into control fields");

  a_soft_reload_latched: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    load_soft & strap_done |=> bmc[BMC_DUPLEX] == strap_latched.duplex_select_pin_option
                               && bmc[BMC_ISOLATE] == strap_latched.interface_isolate_pin_option
                               && bmc[BMC_SPEED] == strap_latched.speed_select_pin_option)
    else $error("soft reset did not restore latched straps");

  a_soft_reset_clears: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    wr_bmc & wdata[BMC_RESET] |=> bmc_view[BMC_RESET] ##[1:SRST_BOUND] !bmc_view[BMC_RESET])
    else $error("soft reset bit did not clear itself");

  a_forced_speed_out: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    !bmc[BMC_AUTONEG] |=> phy_config.speed_100 == $past(bmc[BMC_SPEED]))
    else $error("forced speed output does not follow control bit");

  a_isolate_out: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    ##1 phy_config.mac_isolate == $past(bmc[BMC_ISOLATE]))
    else $error("isolate output does not follow control bit");

  a_w0c_zero_clears: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    wr_int1 & !wdata[INT_RX_ERROR] & !phy_state.rx_error_event |=> !int_flags[INT_RX_ERROR])
    else $error("writing zero did not clear flag");

  a_w0c_one_keeps: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    wr_int1 & wdata[INT_LINK_CHANGE] & int_flags[INT_LINK_CHANGE] |=> int_flags[INT_LINK_CHANGE])
    else $error("writing one changed flag");

  a_hw_counter_step: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    phy_state.rx_error_event & !clr_rx & (rx_err_cnt != COUNTER_MAX)
    |=> rx_err_cnt == $past(rx_err_cnt) + 16'h0001)
    else $error("receive error counter missed an event");

  a_event_beats_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    phy_state.false_carrier_event & clr_fc |=> false_carr_cnt == 16'h0001)
    else $error("event lost against read clear");

  // bus response, storage, outputs, strap copy and counter clear
  a_bus_okay: assert property ( // R4
    hresp == HRESP_OKAY)
    else $error("error response driven");

  a_plain_write_lands: assert property ( // R4
    wr_plain |=> mem[$past(wr_slot)] == $past(wdata))
    else $error("plain write did not land");

  a_forced_duplex_out: assert property ( // R2
    !bmc[BMC_AUTONEG] |=> phy_config.full_duplex == $past(bmc[BMC_DUPLEX]))
    else $error("forced duplex output wrong");

  a_straps_valid_out: assert property ( // R8
    load_hard |=> ##1 phy_config.straps_valid)
    else $error("strap capture not reported");

  a_soft_active_out: assert property ( // R9
    srst_cnt != 8'h00 |=> phy_config.soft_reset_active)
    else $error("soft reset not reported");

  a_latched_straps_kept: assert property ( // R9
    strap_done |=> $stable(strap_latched))
    else $error("latched straps changed");

  a_read_clears_count: assert property ( // R7
    clr_rx & !phy_state.rx_error_event |=> rx_err_cnt == 16'h0000)
    else $error("read did not clear counter");

endmodule

`default_nettype wire

// *** phy_strap_and_register_map_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module phy_strap_and_register_map_tb import phy_regmap_pkg::*;;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] rv;
  strap_pins_s straps, st;
  phy_state_s  pst;
  phy_config_s cfg;
  int          n_errors = 0, n_compared = 0, cycles = 0;

  // -------------------------------------------------------
  // design, controller model and clock
  // -------------------------------------------------------
  assign hready = hreadyout;
  phy_strap_and_register_map #(.SRST_CYCLES(2)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .strap_pins(straps), .phy_state(pst), .phy_config(cfg));
  mgmt_master mgr (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // hang guard, a few hundred cycles are needed
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  // -------------------------------------------------------
  // tasks
  // -------------------------------------------------------
  task automatic wr(input logic [11:0] o, input logic [15:0] d);
    mgr.xfer(1'b1, o, d, rv);
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] o, input logic [15:0] e);
    mgr.xfer(1'b0, o, 16'h0, rv);
    `CHK(nm, e, rv)
    `CHK("hresp", HRESP_OKAY, hresp)
  endtask
  // straps held through reset and well past release
  task automatic hard_reset(input strap_pins_s s);
    @(posedge hclk);
    hresetn <= 1'b0;
    straps  <= s;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 10 && cfg.straps_valid !== 1'b1; i++) @(posedge hclk);
  endtask
  task automatic pulse(input int b, input int w = 0);
    repeat (w) @(posedge hclk);
    @(posedge hclk);
    pst[b] <= 1'b1;
    @(posedge hclk);
    pst[b] <= 1'b0;
  endtask
  function automatic logic [15:0] bmc_exp(input strap_pins_s s);
    return 16'h1000 | {2'h0, s.speed_select_pin_option, 2'h0, s.interface_isolate_pin_option, 1'b0,
      s.duplex_select_pin_option, 8'h0};
  endfunction
  function automatic logic plain(input logic [11:0] o);
    return !(o inside {OFS_BASIC_MODE_CONTROL, OFS_BASIC_MODE_STATUS, OFS_IDENTIFIER_UPPER, OFS_IDENTIFIER_LOWER,
      OFS_PHY_STATUS, OFS_INTERRUPT_STATUS_ONE, OFS_FALSE_CARRIER_COUNTER, OFS_RECEIVE_ERROR_COUNTER});
  endfunction
  task automatic conclude();
    $display("errors %0d of %0d compared", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // -------------------------------------------------------
  // test sequence
  // -------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    straps = '0;
    pst = '0;
    // both levels of every strap, across two hard resets
    for (int k = 0; k < 2; k++) begin
      st = k ? 3'b110 : 3'b001;
      hard_reset(st);
      rd_chk("strapped control", OFS_BASIC_MODE_CONTROL, bmc_exp(st));
      `CHK("mac_isolate", st.interface_isolate_pin_option, cfg.mac_isolate)
    end
    wr(OFS_BASIC_MODE_CONTROL, 16'h0000);
    repeat (2) @(posedge hclk);
    #1 `CHK("forced speed", 1'b0, cfg.speed_100)
    `CHK("forced duplex", 1'b0, cfg.full_duplex)
    wr(OFS_BASIC_MODE_CONTROL, 16'h6900);
    rd_chk("forced control", OFS_BASIC_MODE_CONTROL, 16'h6900);
    `CHK("forced speed", 1'b1, cfg.speed_100)
    `CHK("config", 8'hcd, cfg)
    // pins moved: soft reset must still use the latched copy
    straps <= 3'b001;
    wr(OFS_BASIC_MODE_CONTROL, 16'h8000);
    rv = 16'h8000;
    for (int i = 0; i < 20 && rv[BMC_RESET] !== 1'b0; i++) mgr.xfer(1'b0, OFS_BASIC_MODE_CONTROL, 16'h0, rv);
    `CHK("soft reset control", bmc_exp(3'b110), rv)
    for (int i = 0; i < NUM_REGS; i++) if (plain(REG_OFFSETS[i])) wr(REG_OFFSETS[i], REG_OFFSETS[i] ^ 16'ha5c3);
    for (int i = 0; i < NUM_REGS; i++)
      if (plain(REG_OFFSETS[i])) rd_chk("listed", REG_OFFSETS[i], REG_OFFSETS[i] ^ 16'ha5c3);
    wr(OFS_IDENTIFIER_LOWER, 16'h0000);
    rd_chk("identifier lower", OFS_IDENTIFIER_LOWER, ID_LOWER_VALUE);
    rd_chk("reserved", 12'h00c, 16'h0000);
    rd_chk("reserved", 12'h01d, 16'h0000);
    pulse(1);
    rd_chk("int status", OFS_INTERRUPT_STATUS_ONE, 16'h1 << INT_RX_ERROR);
    wr(OFS_INTERRUPT_STATUS_ONE, 16'hffff);
    rd_chk("int status kept", OFS_INTERRUPT_STATUS_ONE, 16'h1 << INT_RX_ERROR);
    wr(OFS_INTERRUPT_STATUS_ONE, 16'h0000);
    rd_chk("int status cleared", OFS_INTERRUPT_STATUS_ONE, 16'h0000);
    repeat (3) pulse(0);
    // a new event lands in the very cycle the read clears the count
    fork
      rd_chk("false carriers", OFS_FALSE_CARRIER_COUNTER, 16'h0003);
      pulse(0, 1);
    join
    rd_chk("false carriers", OFS_FALSE_CARRIER_COUNTER, 16'h0001);
    rd_chk("rx errors", OFS_RECEIVE_ERROR_COUNTER, 16'h0001);
    pst.link_up <= 1'b1;
    rd_chk("status", OFS_BASIC_MODE_STATUS, BMS_ABILITIES | 16'h0004);
    conclude();
  end
endmodule

`default_nettype wire
